// ### rtl/status_restart_control.v
// status word upper fields: restart slot, forced deferral, bank select,
// access-bit fault disable, and the update/serialization sequencing.
// assumes: pipeline gives one-cycle event pulses, one event class per cycle
// Function
// - restart at slot 2 when slot field holds 2; 3 reserved
// - slot field defined only at interruption and first restart after return
// - legacy interruption clears slot field; legacy restart ignores it
// - deferral set and speculative load: mark target deferred, skip memory, keep increment
// - deferred advanced load purges matching advanced load table entry
// - deferred line prefetch: no promotion, keep post increment
// - deferral clear or other instruction: no forced deferral
// - bank bit maps banked registers; only interruption (clears it), return and bank swap write it
// - bank change drains old bank accesses before new bank used
// - fault disable suppresses access-bit fault on first restart instruction only
// - one-shot bits cleared after each successful instruction except return
// - legacy restart ignores one-shot bits; cleared by legacy branch or return; here return loads them from its value instead
// - user mask changes implicit; system mask changes need explicit serialization; here only sets wait for it, clears of any system mask bit apply at once
// - page walks for fetch see new bit after instruction serialization
// - interrupt mask clear immediate; set needs data serialization
// - privilege level changes only on interruption, return, promote, branch return
// - return-only bits written solely by return, which serializes
// - legacy set indicator change by branch serializes instructions
// - machine check mask set on abort or soft restart, else unchanged
// - firmware-handled interruption clears flagged bits, else kept
`timescale 1ns/1ps
`default_nettype none
`include "status_restart_map.vh"
module status_restart_control (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // interruption events
    input  wire        i_intr,
    input  wire        i_intr_legacy,
    input  wire [1:0]  i_intr_slot,
    input  wire [1:0]  i_intr_cpl,
    input  wire        i_intr_mca,
    input  wire        i_intr_fw,
    // return from interruption
    input  wire        i_rfi,
    input  wire [63:0] i_rfi_value,
    // other status writers
    input  wire        i_bank_swap,
    input  wire        i_bank_swap_val,
    input  wire        i_priv_promote,
    input  wire        i_branch_return,
    input  wire [1:0]  i_new_cpl,
    input  wire        i_branch_legacy,
    input  wire        i_user_mask_wr,
    input  wire [63:0] i_user_mask_val,
    input  wire        i_sys_mask_set,
    input  wire        i_sys_mask_clr,
    input  wire [63:0] i_sys_mask_val,
    input  wire        i_srlz_d,
    input  wire        i_srlz_i,
    // instruction completion and restart information
    input  wire        i_instr_done,
    input  wire        i_first_restart,
    input  wire        i_restart_legacy,
    input  wire        i_spec_load,
    input  wire        i_adv_load,
    input  wire        i_line_prefetch,
    input  wire        i_access_fault,
    input  wire        i_bank_drained,
    // status outputs
    output reg  [63:0] o_status_word,
    output reg  [1:0]  o_restart_slot,
    output reg         o_slot_valid,
    output reg         o_force_deferred,
    output reg         o_skip_memory,
    output reg         o_purge_alt,
    output reg         o_no_promote,
    output reg         o_suppress_fault,
    output reg         o_bank_active,
    output reg         o_bank_stall,
    output reg         o_intr_masked,
    output reg         o_walk_status_bit,
    output reg         o_serialize_i
);
    // ********************************************
    // local state
    // ********************************************
    reg  [63:0] sw_r;
    reg  [63:0] sw_nxt;
    reg         slot_def_r;
    reg         bank_pend_r;
    reg         walk_r;
    reg         mask_seen_r;
    wire [63:0] sys_vis;
    wire        sys_pend;
    wire        ri_ok;
    wire        defer_now;

    function is_ok_slot;
        input [1:0] s;
        begin
            is_ok_slot = (s != `RI_RSVD);
        end
    endfunction

    // ********************************************
    // system mask serialization
    // ********************************************
    // system mask sets deferred; clears applied at once in next value
    sw_ser_tracker ser_u (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_load      (i_sys_mask_set | i_sys_mask_clr),
        .i_value     (i_sys_mask_set ? (sw_r | (i_sys_mask_val & `SM_MASK))
                                     : (sw_r & ~(i_sys_mask_val & `SM_MASK))),
        .i_serialize (i_srlz_d | i_srlz_i | i_rfi),
        .o_visible   (sys_vis),
        .o_pending   (sys_pend)
    );

    // ********************************************
    // status word next value
    // ********************************************
    always @* begin
        sw_nxt = sw_r;
        if (i_intr) begin
            sw_nxt[`SW_RI_HI:`SW_RI_LO] = i_intr_slot;
            if (i_intr_legacy)
                sw_nxt[`SW_RI_HI:`SW_RI_LO] = `RI_SLOT0;
            sw_nxt[`SW_ED_BIT] = 1'b0;
            sw_nxt[`SW_BN_BIT] = 1'b0;
            sw_nxt[`SW_IA_BIT] = 1'b0;
            sw_nxt[`SW_ID_BIT] = 1'b0;
            sw_nxt[`SW_DA_BIT] = 1'b0;
            sw_nxt[`SW_DD_BIT] = 1'b0;
            sw_nxt[`SW_SS_BIT] = 1'b0;
            sw_nxt[`SW_CPL_HI:`SW_CPL_LO] = i_intr_cpl;
            if (i_intr_mca)
                sw_nxt[`SW_MC_BIT] = 1'b1;
            if (i_intr_fw)
                sw_nxt[`SW_IT_BIT] = 1'b0;
        end else if (i_rfi) begin
            sw_nxt = i_rfi_value;
        end else begin
            if (i_bank_swap)
                sw_nxt[`SW_BN_BIT] = i_bank_swap_val;
            if (i_priv_promote | i_branch_return)
                sw_nxt[`SW_CPL_HI:`SW_CPL_LO] = i_new_cpl;
            if (i_user_mask_wr)
                sw_nxt = (sw_nxt & ~`UM_MASK) | (i_user_mask_val & `UM_MASK);
            if (i_sys_mask_clr)
                sw_nxt = sw_nxt & ~(i_sys_mask_val & `SM_MASK);
            else if (sys_pend & (i_srlz_d | i_srlz_i))
                sw_nxt = (sw_nxt & ~`SM_MASK) | (sys_vis & `SM_MASK);
            if (i_branch_legacy) begin
                sw_nxt[`SW_IS_BIT] = 1'b1;
                sw_nxt[`SW_ED_BIT] = 1'b0;
                sw_nxt[`SW_IA_BIT] = 1'b0;
                sw_nxt[`SW_ID_BIT] = 1'b0;
                sw_nxt[`SW_DA_BIT] = 1'b0;
                sw_nxt[`SW_DD_BIT] = 1'b0;
            end
            if (i_instr_done) begin
                sw_nxt[`SW_ED_BIT] = 1'b0;
                sw_nxt[`SW_IA_BIT] = 1'b0;
                sw_nxt[`SW_ID_BIT] = 1'b0;
                sw_nxt[`SW_DA_BIT] = 1'b0;
                sw_nxt[`SW_DD_BIT] = 1'b0;
            end
        end
        sw_nxt[`SW_RV_HI:`SW_RV_LO] = 18'h0_0000;
    end

    // ********************************************
    // restart decode
    // ********************************************
    // slot check
    assign ri_ok = is_ok_slot(sw_r[`SW_RI_HI:`SW_RI_LO]) & slot_def_r;
    assign defer_now = sw_r[`SW_ED_BIT] & i_first_restart & ~i_restart_legacy;

    // ********************************************
    // registers
    // ********************************************
    always @(posedge i_clk) begin
        if (i_rst) begin
            sw_r              <= `SW_RESET_VAL;
            slot_def_r        <= 1'b0;
            bank_pend_r       <= 1'b0;
            walk_r            <= 1'b0;
            mask_seen_r       <= 1'b0;
            o_status_word     <= `SW_RESET_VAL;
            o_restart_slot    <= `RI_SLOT0;
            o_slot_valid      <= 1'b0;
            o_force_deferred  <= 1'b0;
            o_skip_memory     <= 1'b0;
            o_purge_alt       <= 1'b0;
            o_no_promote      <= 1'b0;
            o_suppress_fault  <= 1'b0;
            o_bank_active     <= 1'b0;
            o_bank_stall      <= 1'b0;
            o_intr_masked     <= 1'b1;
            o_walk_status_bit <= 1'b0;
            o_serialize_i     <= 1'b0;
        end else begin
            sw_r          <= sw_nxt;
            o_status_word <= sw_nxt;
            if (i_intr | i_rfi)
                slot_def_r <= 1'b1;
            else if (i_instr_done)
                slot_def_r <= 1'b0;
            o_slot_valid   <= ri_ok & ~i_restart_legacy;
            o_restart_slot <= i_restart_legacy ? `RI_SLOT0 : sw_r[`SW_RI_HI:`SW_RI_LO];
            o_force_deferred <= defer_now & i_spec_load;
            o_skip_memory    <= defer_now & (i_spec_load | i_line_prefetch);
            o_purge_alt      <= defer_now & i_spec_load & i_adv_load;
            o_no_promote     <= defer_now & i_line_prefetch;
            o_suppress_fault <= sw_r[`SW_IA_BIT] & i_first_restart & ~i_restart_legacy
                                & i_access_fault;
            if ((i_intr | i_rfi | i_bank_swap) & (sw_nxt[`SW_BN_BIT] != sw_r[`SW_BN_BIT]))
                bank_pend_r <= 1'b1;
            else if (i_bank_drained)
                bank_pend_r <= 1'b0;
            o_bank_stall <= bank_pend_r & ~i_bank_drained;
            if (~bank_pend_r | i_bank_drained)
                o_bank_active <= sw_r[`SW_BN_BIT];
            if (i_sys_mask_clr & i_sys_mask_val[`SW_I_BIT])
                mask_seen_r <= 1'b1;
            else if (i_srlz_d | i_srlz_i | i_rfi)
                mask_seen_r <= ~sw_nxt[`SW_I_BIT];
            o_intr_masked <= ~sw_nxt[`SW_I_BIT] | mask_seen_r;
            // walker sees bit after instruction serialization
            if (i_srlz_i | i_rfi)
                walk_r <= sw_nxt[`SW_IT_BIT];
            o_walk_status_bit <= walk_r;
            o_serialize_i <= i_branch_legacy | i_rfi;
        end
    end
endmodule
`default_nettype wire

// ### rtl/status_restart_map.vh
// constants for the status word upper fields and update sequencing
// assumes: included by the status control logic only
`ifndef STATUS_RESTART_MAP_VH
`define STATUS_RESTART_MAP_VH
`define SW_WIDTH        64
`define SW_RI_LO        41
`define SW_RI_HI        42
`define SW_ED_BIT       43
`define SW_BN_BIT       44
`define SW_IA_BIT       45
`define SW_RV_LO        46
`define SW_RV_HI        63
`define SW_MC_BIT       35
`define SW_IS_BIT       34
`define SW_I_BIT        14
`define SW_CPL_LO       32
`define SW_CPL_HI       33
`define SW_ID_BIT       37
`define SW_DA_BIT       38
`define SW_DD_BIT       39
`define SW_SS_BIT       40
`define SW_IT_BIT       36
`define RI_SLOT0        2'h0
`define RI_SLOT1        2'h1
`define RI_SLOT2        2'h2
`define RI_RSVD         2'h3
`define SW_RESET_VAL    64'h0000_0000_0000_0000
`define UM_MASK         64'h0000_0000_0000_003F
`define SM_MASK         64'h0000_0000_00FF_FFC0
`endif

// ### rtl/sw_ser_tracker.v
// serialization tracker: holds a pending system mask image until serialized
// assumes: commit pulses and serialize pulses come from the pipeline clock domain
`timescale 1ns/1ps
`default_nettype none
`include "status_restart_map.vh"
module sw_ser_tracker (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // requests
    input  wire        i_load,
    input  wire [63:0] i_value,
    input  wire        i_serialize,
    // visible value
    output reg  [63:0] o_visible,
    output reg         o_pending
);
    // image held ready so the serializing edge can apply it at once
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_visible <= `SW_RESET_VAL;
            o_pending <= 1'b0;
        end else begin
            if (i_load) begin
                o_visible <= i_value;
                o_pending <= ~i_serialize;
            end else if (i_serialize) begin
                o_pending <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/pipe_model.sv
// pipeline model: restart qualifiers by kind, old-bank drain after a delay
// assumes: i_kind and i_slow change at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
    // clock and controls
    input  wire logic       i_clk,
    input  wire logic [2:0] i_kind,
    input  wire logic       i_slow,
    input  wire logic       i_stall,
    // restart qualifiers
    output logic            o_first,
    output logic            o_legacy,
    output logic            o_spec,
    output logic            o_adv,
    output logic            o_pref,
    output logic            o_fault,
    output logic            o_drained
);
    logic [2:0] wait_r;
    assign o_first  = (i_kind != 3'h0);
    assign o_spec   = (i_kind == 3'h1) | (i_kind == 3'h2) | (i_kind == 3'h5);
    assign o_adv    = (i_kind == 3'h2);
    assign o_pref   = (i_kind == 3'h3);
    assign o_fault  = (i_kind == 3'h4) | (i_kind == 3'h5);
    assign o_legacy = (i_kind == 3'h5);
    always @(posedge i_clk) wait_r <= i_stall ? wait_r + 3'h1 : 3'h0;
    assign o_drained = i_stall & (wait_r >= (i_slow ? 3'h4 : 3'h1));
endmodule
`default_nettype wire

// ### testbench/status_restart_control_sva.sv
// checker for the status word upper fields
// assumes: bound to the status control top, one event class per cycle
`timescale 1ns/1ps
`default_nettype none
module status_restart_control_sva (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_intr,
    input wire logic        i_intr_legacy,
    input wire logic [1:0]  i_intr_slot,
    input wire logic        i_intr_mca,
    input wire logic        i_rfi,
    input wire logic [63:0] i_rfi_value,
    input wire logic        i_sys_mask_clr,
    input wire logic [63:0] i_sys_mask_val,
    input wire logic        i_instr_done,
    input wire logic        i_first_restart,
    input wire logic        i_restart_legacy,
    input wire logic        i_spec_load,
    input wire logic [63:0] o_status_word,
    input wire logic        o_force_deferred,
    input wire logic        o_skip_memory,
    input wire logic        o_intr_masked
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_slot_on_intr: assert property (i_intr && !i_intr_legacy |=>
        o_status_word[42:41] == $past(i_intr_slot)) else $error("slot field wrong after interruption");
    chk_legacy_slot: assert property (i_intr && i_intr_legacy |=> o_status_word[42:41] == 2'h0)
        else $error("slot field not cleared after legacy interruption");
    chk_intr_clears: assert property (i_intr |=> o_status_word[45:43] == 3'h0)
        else $error("one-shot or bank bits not cleared on interruption");
    chk_rsvd_zero: assert property (o_status_word[63:46] == 18'h0)
        else $error("reserved bits not zero");
    chk_force_defer: assert property (i_first_restart && i_spec_load && !i_restart_legacy
        && o_status_word[43] |=> o_force_deferred && o_skip_memory) else $error("deferral not forced");
    chk_no_defer: assert property (!o_status_word[43] |=> !o_force_deferred)
        else $error("deferral forced with bit clear");
    chk_one_shot: assert property (i_instr_done && !i_rfi && !i_intr |=>
        o_status_word[45] == 1'b0 && o_status_word[43] == 1'b0) else $error("one-shot bits kept");
    chk_mc_mask: assert property (i_intr |=>
        o_status_word[35] == ($past(i_intr_mca) | $past(o_status_word[35]))) else $error("mc mask wrong");
    chk_mask_clr: assert property (i_sys_mask_clr && i_sys_mask_val[14] && !i_intr && !i_rfi |=>
        o_intr_masked && !o_status_word[14]) else $error("interrupt mask clear late");
    chk_rfi_load: assert property (i_rfi && !i_intr |=>
        o_status_word[45:0] == $past(i_rfi_value[45:0])) else $error("return did not load status");
    cover property (i_intr && i_intr_legacy);
    cover property (o_force_deferred);
    cover property (i_sys_mask_clr ##1 o_intr_masked);
endmodule
bind status_restart_control status_restart_control_sva status_restart_control_sva_i (.*);
`default_nettype wire

// ### testbench/tb_top.sv
// testbench for the status word control block
// assumes: pipeline model drives restart qualifiers and bank drain
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam [19:0] dec_tab = 20'h0_12C8;
    reg         i_clk, i_rst, leg, mca, fw, bsv, slow;
    reg  [11:0] ev;
    reg  [63:0] val, e;
    reg  [1:0]  slot, current_privilege_level;
    reg  [2:0]  kind;
    integer     mismatches, n_compared, j;
    wire [63:0] sw;
    wire [1:0]  rslot;
    wire        fdef, skip, purge, nopro, supp, bact, bstall, masked, seri;
    wire        first, rleg, spec, adv, pref, fault, drained, sval, walk;
    status_restart_control status_restart_control_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_intr(ev[0]), .i_intr_legacy(leg), .i_intr_slot(slot), .i_intr_cpl(current_privilege_level), .i_intr_mca(mca),
        .i_intr_fw(fw), .i_rfi(ev[1]), .i_rfi_value(val), .i_bank_swap(ev[2]), .i_bank_swap_val(bsv),
        .i_priv_promote(ev[3]), .i_branch_return(ev[4]), .i_new_cpl(current_privilege_level), .i_branch_legacy(ev[5]),
        .i_user_mask_wr(ev[6]), .i_user_mask_val(val), .i_sys_mask_set(ev[7]), .i_sys_mask_clr(ev[8]),
        .i_sys_mask_val(val), .i_srlz_d(ev[9]), .i_srlz_i(ev[10]), .i_instr_done(ev[11]),
        .i_first_restart(first), .i_restart_legacy(rleg), .i_spec_load(spec), .i_adv_load(adv),
        .i_line_prefetch(pref), .i_access_fault(fault), .i_bank_drained(drained), .o_status_word(sw),
        .o_restart_slot(rslot), .o_slot_valid(sval), .o_force_deferred(fdef), .o_skip_memory(skip),
        .o_purge_alt(purge), .o_no_promote(nopro), .o_suppress_fault(supp), .o_bank_active(bact),
        .o_bank_stall(bstall), .o_intr_masked(masked), .o_walk_status_bit(walk), .o_serialize_i(seri));
    pipe_model pipe_model_i (.i_clk(i_clk), .i_kind(kind), .i_slow(slow), .i_stall(bstall),
        .o_first(first), .o_legacy(rleg), .o_spec(spec), .o_adv(adv), .o_pref(pref),
        .o_fault(fault), .o_drained(drained));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task chk(input [63:0] s, input [63:0] x, input [8*8:1] n);
        begin
            n_compared = n_compared + 1;
            if (s !== x) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0s expected %h seen %h", n, x, s);
            end
        end
    endtask
    task go(input integer k);
        begin
            @(negedge i_clk) ev[k] = 1'b1;
            @(negedge i_clk) ev = 12'h000;
        end
    endtask
    task complete_run;
        begin
            $display("mismatches %0d compared %0d", mismatches, n_compared);
            if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // ****************
    // stimulus
    // ****************
    initial begin
        {i_rst, ev, val, slot, current_privilege_level, kind, leg, mca, fw, bsv, slow} = {1'b1, 88'h0};
        mismatches = 0;
        n_compared = 0;
        repeat (4) @(negedge i_clk);
        i_rst = 1'b0;
        chk({sw, masked}, 65'h1, "reset");
        val = 64'hFFFF_FC00_0000_4000;
        go(1);
        chk(sw, 64'h0000_3C00_0000_4000, "rfi");
        for (j = 1; j <= 5; j = j + 1) begin
            kind = j[2:0];
            @(negedge i_clk);
            chk({fdef, purge, nopro, supp}, dec_tab[4*j-4 +: 4], "decode");
            if (j == 1) chk({skip, rslot, sval}, 4'hD, "skipslot");
        end
        kind = 3'h0;
        chk(masked, 1'b0, "unmask");
        go(11);
        chk(sw[45:43], 3'h2, "oneshot");
        kind = 3'h1;
        @(negedge i_clk);
        chk(fdef, 1'b0, "nodefer");
        kind = 3'h0;
        slow = 1'b1;
        go(2);
        @(negedge i_clk);
        chk(bstall, 1'b1, "stall");
        for (j = 0; j < 20 && bstall !== 1'b0; j = j + 1) @(negedge i_clk);
        if (j == 20) mismatches = mismatches + 1;
        if (j == 20) complete_run;
        chk({bact, sw[44]}, 2'h0, "bank");
        val = 64'h0000_0000_0000_4000;
        go(8);
        chk({masked, sw[14]}, 2'h2, "mclr");
        go(7);
        chk(sw[14], 1'b0, "mset");
        go(9);
        chk(sw[14], 1'b1, "srlzd");
        val = 64'h0000_0000_0000_003F;
        go(6);
        chk(sw[5:0], 6'h3F, "umask");
        current_privilege_level = 2'h2;
        go(3);
        chk(sw[33:32], 2'h2, "promote");
        current_privilege_level = 2'h1;
        go(4);
        chk(sw[33:32], 2'h1, "brret");
        go(10);
        go(5);
        chk({sw[34], seri}, 2'h3, "legacy");
        for (j = 0; j < 4; j = j + 1) begin
            val = 64'h0000_3810_0000_0000;
            go(1);
            {slot, current_privilege_level, leg, mca, fw} = {j[1:0], j[1:0], j == 3, j == 1, j == 2};
            go(0);
            e = 64'h0;
            e[42:41] = leg ? 2'h0 : slot;
            {e[36], e[35], e[33:32]} = {!fw, mca, current_privilege_level};
            chk(sw & 64'h0000_3E1B_0000_0000, e, "intr");
            chk(walk, 1'b1, "walk");
        end
        complete_run;
    end
endmodule
`default_nettype wire
